/* File: inc/acr_pkg.sv */
// constants and types for the converter configuration register bank
package acr_pkg;
    localparam int NUM_CH   = 4;
    localparam int SAMPLE_W = 12;

    // register addresses on the serial port
    localparam logic [7:0] ADDR_CHAN_SELECT = 8'h05;
    localparam logic [7:0] ADDR_POWER_MODE  = 8'h08;
    localparam logic [7:0] ADDR_CLOCK       = 8'h09;
    localparam logic [7:0] ADDR_PATTERN     = 8'h0D;
    localparam logic [7:0] ADDR_FORMAT      = 8'h14;
    localparam logic [7:0] ADDR_COMMIT      = 8'hFF;

    // reset values
    localparam logic [7:0] RST_CHAN_SELECT = 8'h0F;
    localparam logic [7:0] RST_POWER_MODE  = 8'h00;
    localparam logic [7:0] RST_CLOCK       = 8'h01;
    localparam logic [7:0] RST_PATTERN     = 8'h00;
    localparam logic [7:0] RST_FORMAT      = 8'h00;
    localparam logic [7:0] RST_COMMIT      = 8'h00;

    // field masks and positions
    localparam logic [7:0] MASK_CHAN_SELECT = 8'h3F;
    localparam logic [7:0] MASK_POWER_MODE  = 8'h07;
    localparam logic [7:0] MASK_CLOCK       = 8'h01;
    localparam logic [7:0] MASK_FORMAT      = 8'h47;
    localparam int         COMMIT_BIT       = 0;
    localparam int         DCS_BIT          = 0;
    localparam int         PRBS_LONG_RST_BIT  = 5;
    localparam int         PRBS_SHORT_RST_BIT = 4;
    localparam int         FMT_LOW_POWER_BIT  = 6;
    localparam int         FMT_INVERT_BIT     = 2;

    // power mode codes
    localparam logic [2:0] PM_RUN      = 3'h0;
    localparam logic [2:0] PM_POWERDN  = 3'h1;
    localparam logic [2:0] PM_STANDBY  = 3'h2;
    localparam logic [2:0] PM_RESET    = 3'h3;

    // data coding
    localparam logic [1:0] CODE_OFFSET = 2'h0;
    localparam logic [1:0] CODE_TWOS   = 2'h1;

    // test mode codes
    localparam logic [3:0] TM_OFF        = 4'h0;
    localparam logic [3:0] TM_MIDSCALE   = 4'h1;
    localparam logic [3:0] TM_POS_FS     = 4'h2;
    localparam logic [3:0] TM_NEG_FS     = 4'h3;
    localparam logic [3:0] TM_CHECKER    = 4'h4;
    localparam logic [3:0] TM_LONG_PRBS  = 4'h5;
    localparam logic [3:0] TM_SHORT_PRBS = 4'h6;
    localparam logic [3:0] TM_WORD_TOG   = 4'h7;
    localparam logic [3:0] TM_USER       = 4'h8;
    localparam logic [3:0] TM_BIT_TOG    = 4'h9;
    localparam logic [3:0] TM_SYNC       = 4'hA;
    localparam logic [3:0] TM_ONE_HIGH   = 4'hB;
    localparam logic [3:0] TM_MIXED      = 4'hC;

    // test words in offset binary
    localparam logic [11:0] PAT_MIDSCALE   = 12'h800;
    localparam logic [11:0] PAT_POS_FS     = 12'hFFF;
    localparam logic [11:0] PAT_NEG_FS     = 12'h000;
    localparam logic [11:0] PAT_CHECKER_A  = 12'hAAA;
    localparam logic [11:0] PAT_CHECKER_B  = 12'h555;
    localparam logic [11:0] PAT_WORD_ONES  = 12'hFFF;
    localparam logic [11:0] PAT_WORD_ZEROS = 12'h000;
    localparam logic [11:0] PAT_BIT_TOG    = 12'hAAA;
    localparam logic [11:0] PAT_SYNC       = 12'h03F;
    localparam logic [11:0] PAT_ONE_HIGH   = 12'h800;
    localparam logic [11:0] PAT_MIXED      = 12'hA33;

    // pseudorandom generators
    localparam int LONG_ORDER  = 23;
    localparam int LONG_TAP    = 18;
    localparam int SHORT_ORDER = 9;
    localparam int SHORT_TAP   = 5;

    // serial frame layout
    localparam logic [4:0] LAST_INSTR_BIT = 5'd15;
    localparam logic [4:0] LAST_FRAME_BIT = 5'd23;
    localparam int         RW_BIT         = 15;

    typedef enum logic [1:0] {SPI_INSTR, SPI_DATA, SPI_DONE} acr_spi_state_t;
endpackage

/* File: verilog/acr_prbs.sv */
// pseudorandom word generator, twelve bits per advance
`timescale 1ns/1ps
module acr_prbs
    import acr_pkg::*;
#(
    parameter int ORDER = 9,
    parameter int TAP   = 5
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        hold,
    input  wire logic        advance,
    output logic [11:0]      word
);
    logic [ORDER-1:0] state;
    logic [ORDER-1:0] next_state;
    logic [11:0]      next_word;

    always_comb
    begin
        next_state = state;
        next_word  = 12'h000;
        for (int i = 0; i < SAMPLE_W; i++)
        begin
            next_word[SAMPLE_W-1-i] = next_state[ORDER-1];
            next_state = {next_state[ORDER-2:0], next_state[ORDER-1] ^ next_state[TAP-1]};
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || hold)
        begin
            state <= '1;
            word  <= 12'h000;
        end
        else if (advance)
        begin
            state <= next_state;
            word  <= next_word;
        end
    end
endmodule

/* File: verilog/acr_fmt.sv */
// per-channel output word selection and formatting
`timescale 1ns/1ps
module acr_fmt
    import acr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        strobe,
    input  wire logic [7:0]  pattern_cfg,
    input  wire logic [7:0]  format_cfg,
    input  wire logic [11:0] sample,
    input  wire logic [11:0] user_word,
    input  wire logic [11:0] long_word,
    input  wire logic [11:0] short_word,
    output logic [11:0]      data_out
);
    logic        phase;
    logic [11:0] raw;
    logic [11:0] coded;

    always_comb
    begin
        case (pattern_cfg[3:0])
            TM_OFF:        raw = sample;
            TM_MIDSCALE:   raw = PAT_MIDSCALE;
            TM_POS_FS:     raw = PAT_POS_FS;
            TM_NEG_FS:     raw = PAT_NEG_FS;
            TM_CHECKER:    raw = phase ? PAT_CHECKER_B : PAT_CHECKER_A;
            TM_LONG_PRBS:  raw = long_word;
            TM_SHORT_PRBS: raw = short_word;
            TM_WORD_TOG:   raw = phase ? PAT_WORD_ZEROS : PAT_WORD_ONES;
            TM_USER:       raw = user_word;
            TM_BIT_TOG:    raw = PAT_BIT_TOG;
            TM_SYNC:       raw = PAT_SYNC;
            TM_ONE_HIGH:   raw = PAT_ONE_HIGH;
            TM_MIXED:      raw = PAT_MIXED;
            default:       raw = sample;
        endcase
    end

    // reserved codings fall back to offset binary
    always_comb
    begin
        coded = raw;
        if (format_cfg[1:0] == CODE_TWOS)
            coded[SAMPLE_W-1] = ~raw[SAMPLE_W-1];
        if (format_cfg[FMT_INVERT_BIT])
            coded = ~coded;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            phase    <= 1'b0;
            data_out <= 12'h000;
        end
        else if (strobe)
        begin
            phase    <= ~phase;
            data_out <= coded;
        end
    end
endmodule

/* File: verilog/acr_top.sv */
// serial-programmed configuration bank with test pattern output path
//
// Overview of operation
// - channel select bits gate per-channel writes
// - power mode: run, power-down, standby, reset
// - clock bit 0 enables duty stabilizer
// - test modes replace sample data on outputs
// - modes: off, midscale, positive, negative full-scale
// - checker, long, short prbs, word toggle
// - user, bit toggle, sync, one high, mixed
// - output format also applies to test words
// - format: low-power swing, invert, twos complement
`timescale 1ns/1ps
module acr_top
    import acr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        spi_csb_n,
    input  wire logic        spi_sclk,
    input  wire logic        spi_sdio_in,
    output logic             spi_sdio_out,
    output logic             spi_sdio_oe,
    input  wire logic        sample_strobe,
    input  wire logic [11:0] sample_in [NUM_CH],
    input  wire logic [11:0] user_pattern,
    output logic [11:0]      data_out [NUM_CH],
    output logic             power_down,
    output logic             standby,
    output logic             core_reset,
    output logic             dcs_enable,
    output logic [3:0]       lvds_low_power
);
    // serial port
    logic            sclk_q;
    logic            sclk_rise;
    logic            sclk_fall;
    acr_spi_state_t  spi_state;
    logic [4:0]      bit_cnt;
    logic [15:0]     shift_in;
    logic [15:0]     instr;
    logic [7:0]      rd_shift;
    logic [7:0]      rd_data;
    logic            wr_en;
    logic [7:0]      wr_addr;
    logic [7:0]      wr_data;

    // registers
    logic [7:0]      chan_select;
    logic [7:0]      shadow_power;
    logic [7:0]      shadow_clock;
    logic [7:0]      shadow_pattern [NUM_CH];
    logic [7:0]      shadow_format  [NUM_CH];
    logic [7:0]      active_power;
    logic [7:0]      active_clock;
    logic [7:0]      active_pattern [NUM_CH];
    logic [7:0]      active_format  [NUM_CH];
    logic            commit_pending;
    logic [1:0]      rd_ch;

    // prbs
    logic            long_hold;
    logic            short_hold;
    logic [11:0]     long_word;
    logic [11:0]     short_word;

    // sclk is sampled on clk_sys, so it must stay below a quarter of its rate
    assign sclk_rise = spi_sclk & ~sclk_q;
    assign sclk_fall = ~spi_sclk & sclk_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            sclk_q <= 1'b0;
        else
            sclk_q <= spi_sclk;
    end

    // frame: 16 instruction bits (read flag on top, address low byte), then one data byte
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || spi_csb_n)
        begin
            spi_state <= SPI_INSTR;
            bit_cnt   <= 5'd0;
            shift_in  <= 16'h0000;
            instr     <= 16'h0000;
        end
        else if (sclk_rise)
        begin
            shift_in <= {shift_in[14:0], spi_sdio_in};
            case (spi_state)
                SPI_INSTR:
                begin
                    bit_cnt <= bit_cnt + 5'd1;
                    if (bit_cnt == LAST_INSTR_BIT)
                    begin
                        instr     <= {shift_in[14:0], spi_sdio_in};
                        spi_state <= SPI_DATA;
                    end
                end
                SPI_DATA:
                begin
                    bit_cnt <= bit_cnt + 5'd1;
                    if (bit_cnt == LAST_FRAME_BIT)
                        spi_state <= SPI_DONE;
                end
                SPI_DONE:
                    bit_cnt <= bit_cnt;
                default:
                    spi_state <= SPI_INSTR;
            endcase
        end
    end

    // one write per frame; further bytes in the frame are ignored
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            wr_en   <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end
        else
        begin
            wr_en <= !spi_csb_n && sclk_rise && spi_state == SPI_DATA
                     && bit_cnt == LAST_FRAME_BIT && !instr[RW_BIT];
            if (!spi_csb_n && sclk_rise && spi_state == SPI_DATA && bit_cnt == LAST_FRAME_BIT)
            begin
                wr_addr <= instr[7:0];
                wr_data <= {shift_in[6:0], spi_sdio_in};
            end
        end
    end

    // read byte shifts out on falling sclk, msb first
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || spi_csb_n)
        begin
            rd_shift     <= 8'h00;
            spi_sdio_out <= 1'b0;
            spi_sdio_oe  <= 1'b0;
        end
        else if (sclk_rise && spi_state == SPI_INSTR && bit_cnt == LAST_INSTR_BIT)
            rd_shift <= rd_data;
        else if (sclk_fall && spi_state == SPI_DATA && instr[RW_BIT])
        begin
            spi_sdio_out <= rd_shift[7];
            spi_sdio_oe  <= 1'b1;
            rd_shift     <= {rd_shift[6:0], 1'b0};
        end
        else if (sclk_fall && spi_state == SPI_DONE)
            spi_sdio_oe <= 1'b0;
    end

    // per-channel readback shows the lowest selected channel
    always_comb
    begin
        if (chan_select[0] || chan_select[3:0] == 4'h0)
            rd_ch = 2'd0;
        else if (chan_select[1])
            rd_ch = 2'd1;
        else if (chan_select[2])
            rd_ch = 2'd2;
        else
            rd_ch = 2'd3;
    end

    // address comes from the live shift register at the last instruction bit
    always_comb
    begin
        case ({shift_in[6:0], spi_sdio_in})
            ADDR_CHAN_SELECT: rd_data = chan_select;
            ADDR_POWER_MODE:  rd_data = shadow_power;
            ADDR_CLOCK:       rd_data = shadow_clock;
            ADDR_PATTERN:     rd_data = shadow_pattern[rd_ch];
            ADDR_FORMAT:      rd_data = shadow_format[rd_ch];
            ADDR_COMMIT:      rd_data = {7'h00, commit_pending};
            default:          rd_data = 8'h00;
        endcase
    end

    // channel select acts at once, not through the shadow
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            chan_select <= RST_CHAN_SELECT;
        else if (wr_en && wr_addr == ADDR_CHAN_SELECT)
            chan_select <= wr_data & MASK_CHAN_SELECT;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            shadow_power <= RST_POWER_MODE;
            shadow_clock <= RST_CLOCK;
        end
        else if (wr_en)
        begin
            if (wr_addr == ADDR_POWER_MODE)
                shadow_power <= wr_data & MASK_POWER_MODE;
            if (wr_addr == ADDR_CLOCK)
                shadow_clock <= wr_data & MASK_CLOCK;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (!rst_n)
            begin
                shadow_pattern[i] <= RST_PATTERN;
                shadow_format[i]  <= RST_FORMAT;
            end
            else if (wr_en && chan_select[i])
            begin
                if (wr_addr == ADDR_PATTERN)
                    shadow_pattern[i] <= wr_data;
                if (wr_addr == ADDR_FORMAT)
                    shadow_format[i] <= wr_data & MASK_FORMAT;
            end
        end
    end

    // commit bit self-clears after the copy; a new commit in that cycle wins
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            commit_pending <= RST_COMMIT[COMMIT_BIT];
        else if (wr_en && wr_addr == ADDR_COMMIT && wr_data[COMMIT_BIT])
            commit_pending <= 1'b1;
        else
            commit_pending <= 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            active_power <= RST_POWER_MODE;
            active_clock <= RST_CLOCK;
            for (int i = 0; i < NUM_CH; i++)
            begin
                active_pattern[i] <= RST_PATTERN;
                active_format[i]  <= RST_FORMAT;
            end
        end
        else if (commit_pending)
        begin
            active_power <= shadow_power;
            active_clock <= shadow_clock;
            for (int i = 0; i < NUM_CH; i++)
            begin
                active_pattern[i] <= shadow_pattern[i];
                active_format[i]  <= shadow_format[i];
            end
        end
    end

    // mode outputs; reserved power codes run the chip
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            power_down <= 1'b0;
            standby    <= 1'b0;
            core_reset <= 1'b0;
        end
        else
        begin
            power_down <= active_power[2:0] == PM_POWERDN;
            standby    <= active_power[2:0] == PM_STANDBY;
            core_reset <= active_power[2:0] == PM_RESET;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            dcs_enable <= RST_CLOCK[DCS_BIT];
        else
            dcs_enable <= active_clock[DCS_BIT];
    end

    always_ff @(posedge clk_sys)
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (!rst_n)
                lvds_low_power[i] <= 1'b0;
            else
                lvds_low_power[i] <= active_format[i][FMT_LOW_POWER_BIT];
        end
    end

    // generators are shared, so any channel's reset bit holds them
    always_comb
    begin
        long_hold  = 1'b0;
        short_hold = 1'b0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            long_hold  = long_hold  | active_pattern[i][PRBS_LONG_RST_BIT];
            short_hold = short_hold | active_pattern[i][PRBS_SHORT_RST_BIT];
        end
    end

    acr_prbs #(.ORDER(LONG_ORDER), .TAP(LONG_TAP)) u_long_prbs
    (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .hold    (long_hold),
        .advance (sample_strobe),
        .word    (long_word)
    );

    acr_prbs #(.ORDER(SHORT_ORDER), .TAP(SHORT_TAP)) u_short_prbs
    (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .hold    (short_hold),
        .advance (sample_strobe),
        .word    (short_word)
    );

    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
        acr_fmt u_fmt
        (
            .clk_sys     (clk_sys),
            .rst_n       (rst_n),
            .strobe      (sample_strobe),
            .pattern_cfg (active_pattern[g]),
            .format_cfg  (active_format[g]),
            .sample      (sample_in[g]),
            .user_word   (user_pattern),
            .long_word   (long_word),
            .short_word  (short_word),
            .data_out    (data_out[g])
        );
    end
endmodule

/* File: dv/acr_chk.sv */
// concurrent port checks for the configuration bank
`timescale 1ns/1ps
module acr_chk
    import acr_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        spi_csb_n,
    input wire logic        spi_sclk,
    input wire logic        spi_sdio_in,
    input wire logic        spi_sdio_out,
    input wire logic        spi_sdio_oe,
    input wire logic        sample_strobe,
    input wire logic [11:0] sample_in [NUM_CH],
    input wire logic [11:0] user_pattern,
    input wire logic [11:0] data_out [NUM_CH],
    input wire logic        power_down,
    input wire logic        standby,
    input wire logic        core_reset,
    input wire logic        dcs_enable,
    input wire logic [3:0]  lvds_low_power
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    rst_vals_a: assert property ($rose(rst_n) |-> dcs_enable && !power_down && !standby && !core_reset
        && lvds_low_power == 4'h0 && data_out[0] == 12'h000 && !spi_sdio_oe)
        else $error("outputs not at reset values");
    pwr_onehot_a: assert property ($onehot0({power_down, standby, core_reset}))
        else $error("power mode outputs overlap");
    out_hold_a: assert property ($changed(data_out[0]) || $changed(data_out[3]) |-> $past(sample_strobe))
        else $error("output word moved without a strobe");
    // config outputs may only move when select was low four cycles earlier
    cfg_commit_a: assert property ($changed({power_down, standby, core_reset, dcs_enable, lvds_low_power})
        |-> !$past(spi_csb_n, 4))
        else $error("active config changed outside a frame");
    oe_idle_a: assert property (spi_csb_n [*3] |-> !spi_sdio_oe)
        else $error("data line driven while deselected");
    oe_rise_a: assert property ($rose(spi_sdio_oe) |-> !spi_csb_n && !$past(spi_csb_n, 2))
        else $error("drive began outside a frame");
    oe_hold_a: assert property ($rose(spi_sdio_oe) |-> spi_sdio_oe [*4])
        else $error("read bit released too early");
    // the line may only fall back to 0 once the frame closes, never rise undriven
    sdo_quiet_a: assert property ($changed(spi_sdio_out)
        |-> spi_sdio_oe || !spi_sdio_out)
        else $error("read data moved while not driving");

    cover property ($rose(power_down));
    cover property ($rose(spi_sdio_oe));
    cover property (sample_strobe ##1 $changed(data_out[0]));
endmodule

/* File: dv/acr_host.sv */
// serial port host model that frames register accesses
`timescale 1ns/1ps
module acr_host
    import acr_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic sdio_out,
    output logic      csb_n,
    output logic      sclk,
    output logic      sdio
);
    initial
    begin
        csb_n = 1'b1;
        sclk  = 1'b0;
        sdio  = 1'b0;
    end

    // three clocks per phase, above the two-clock minimum
    task automatic half();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    // nbits below 24 drops select early to abort
    task automatic xfer(input logic rd, input logic [7:0] addr, input logic [7:0] wd,
                        input int nbits, output logic [7:0] rdo);
        logic [23:0] frm;
        frm = {rd, 7'h00, addr, wd};
        rdo = 8'h00;
        @(posedge clk_sys);
        #1 csb_n = 1'b0;
        for (int i = 23; i > 23 - nbits; i--)
        begin
            sclk = 1'b0;
            sdio = (rd && i < 8) ? ~sdio : frm[i];
            half();
            if (i < 8)
                rdo[i] = sdio_out;
            sclk = 1'b1;
            half();
        end
        sclk = 1'b0;
        half();
        csb_n = 1'b1;
        sdio  = ~sdio;
        half();
    endtask
endmodule

/* File: dv/acr_tb_top.sv */
// self-checking bench for the configuration bank
`timescale 1ns/1ps
module adc_mode_test_output_config_regs_tb_top;
    import acr_pkg::*;
    typedef struct {logic [3:0] tm; logic [7:0] fmt; logic [11:0] raw;} acr_row_t;
    logic        clk_sys       = 1'b0;
    logic        rst_n         = 1'b0;
    logic        sample_strobe = 1'b0;
    logic [11:0] user_pattern  = 12'h5C3;
    logic        csb_n, sclk, host_sdio, dut_sdo, dut_oe, sdio_line;
    logic [11:0] sample_in [NUM_CH];
    logic [11:0] data_out [NUM_CH];
    logic        power_down, standby, core_reset, dcs_enable;
    logic [3:0]  lvds_low_power;
    logic [7:0]  rd;
    logic [11:0] w0;
    int          err_total = 0;
    int          compares  = 0;
    acr_row_t    rows [9];
    logic [7:0]  ra [7] = '{ADDR_CHAN_SELECT, ADDR_POWER_MODE, ADDR_CLOCK, ADDR_PATTERN, ADDR_FORMAT,
                            ADDR_COMMIT, 8'h30};
    logic [7:0]  rv [7] = '{RST_CHAN_SELECT, RST_POWER_MODE, RST_CLOCK, RST_PATTERN, RST_FORMAT,
                            RST_COMMIT, 8'h00};

    always #25 clk_sys = ~clk_sys;
    assign sdio_line = dut_oe ? dut_sdo : host_sdio;

    acr_host host (.clk_sys(clk_sys), .sdio_out(sdio_line), .csb_n(csb_n), .sclk(sclk), .sdio(host_sdio));

    acr_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .spi_csb_n(csb_n), .spi_sclk(sclk),
        .spi_sdio_in(sdio_line), .spi_sdio_out(dut_sdo), .spi_sdio_oe(dut_oe),
        .sample_strobe(sample_strobe), .sample_in(sample_in), .user_pattern(user_pattern),
        .data_out(data_out), .power_down(power_down), .standby(standby), .core_reset(core_reset),
        .dcs_enable(dcs_enable), .lvds_low_power(lvds_low_power));

    task automatic finish_test();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d, 24, rd);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        host.xfer(1'b1, a, 8'h00, 24, rd);
        chk({4'h0, rd}, {4'h0, e});
    endtask

    task automatic strobe();
        sample_strobe = 1'b1;
        @(posedge clk_sys);
        #1 sample_strobe = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    function automatic logic [11:0] fmtw(input logic [11:0] w, input logic [7:0] f);
        fmtw = w ^ {f[1:0] == CODE_TWOS, 11'h000};
        if (f[FMT_INVERT_BIT])
            fmtw = ~fmtw;
    endfunction

    task automatic reset_chk();
        chk({3'h0, lvds_low_power, dcs_enable, power_down, standby, core_reset, 1'b0}, 12'h010);
        chk(data_out[0], 12'h000);
        wr(8'h30, 8'h55);
        foreach (ra[i])
            rdc(ra[i], rv[i]);
    endtask

    // two-valued patterns: whichever comes first, the next strobe must flip
    task automatic alt(input logic [3:0] tm, input logic [11:0] a, input logic [11:0] b);
        wr(ADDR_PATTERN, {4'h0, tm});
        wr(ADDR_COMMIT, 8'h01);
        strobe();
        w0 = data_out[0];
        chk(w0, w0 === a ? a : b);
        strobe();
        chk(data_out[0], w0 === a ? b : a);
    endtask

    task automatic prbs(input logic [3:0] tm, input int rbit, input logic [11:0] mask);
        wr(ADDR_PATTERN, {4'h0, tm} | (8'h01 << rbit));
        wr(ADDR_COMMIT, 8'h01);
        strobe();
        strobe();
        chk(data_out[3], 12'h000);
        wr(ADDR_PATTERN, {4'h0, tm});
        wr(ADDR_COMMIT, 8'h01);
        strobe();
        chk(data_out[0], 12'h000);
        strobe();
        chk(data_out[1], mask);
    endtask

    initial
    begin
        for (int c = 0; c < NUM_CH; c++)
            sample_in[c] = 12'h120 + 12'(c);
        rows = '{'{TM_MIDSCALE, 8'h00, PAT_MIDSCALE}, '{TM_POS_FS, 8'h01, PAT_POS_FS},
                 '{TM_NEG_FS, 8'h04, PAT_NEG_FS}, '{TM_BIT_TOG, 8'h00, PAT_BIT_TOG},
                 '{TM_SYNC, 8'h05, PAT_SYNC}, '{TM_ONE_HIGH, 8'h40, PAT_ONE_HIGH},
                 '{TM_MIXED, 8'h00, PAT_MIXED}, '{TM_USER, 8'h00, user_pattern},
                 '{TM_OFF, 8'h05, 12'h000}};
        repeat (12) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        reset_chk();
        foreach (rows[i])
        begin
            wr(ADDR_PATTERN, {4'h0, rows[i].tm});
            wr(ADDR_FORMAT, rows[i].fmt);
            wr(ADDR_COMMIT, 8'h01);
            strobe();
            for (int c = 0; c < NUM_CH; c++)
                chk(data_out[c], fmtw(rows[i].tm == TM_OFF ? sample_in[c] : rows[i].raw, rows[i].fmt));
            chk({8'h00, lvds_low_power}, {8'h00, {4{rows[i].fmt[FMT_LOW_POWER_BIT]}}});
        end
        // shadow value must not reach the outputs before commit
        wr(ADDR_POWER_MODE, {5'h00, PM_POWERDN});
        chk({11'h000, power_down}, 12'h000);
        rdc(ADDR_POWER_MODE, 8'h01);
        for (int p = 3; p >= 0; p--)
        begin
            wr(ADDR_POWER_MODE, 8'(p));
            wr(ADDR_COMMIT, 8'h01);
            chk({9'h000, core_reset, standby, power_down}, {9'h000, p == 3, p == 2, p == 1});
        end
        wr(ADDR_CLOCK, 8'h00);
        wr(ADDR_COMMIT, 8'h01);
        chk({11'h000, dcs_enable}, 12'h000);
        host.xfer(1'b0, ADDR_CLOCK, 8'h01, 20, rd);
        rdc(ADDR_CLOCK, 8'h00);
        wr(ADDR_CLOCK, 8'h01);
        wr(ADDR_COMMIT, 8'h01);
        chk({11'h000, dcs_enable}, 12'h001);
        wr(ADDR_FORMAT, 8'h00);
        wr(ADDR_CHAN_SELECT, 8'h01);
        wr(ADDR_PATTERN, {4'h0, TM_POS_FS});
        wr(ADDR_COMMIT, 8'h01);
        strobe();
        chk(data_out[0], PAT_POS_FS);
        chk(data_out[1], sample_in[1]);
        wr(ADDR_CHAN_SELECT, 8'h0F);
        alt(TM_CHECKER, PAT_CHECKER_A, PAT_CHECKER_B);
        alt(TM_WORD_TOG, PAT_WORD_ONES, PAT_WORD_ZEROS);
        prbs(TM_LONG_PRBS, PRBS_LONG_RST_BIT, 12'hFFF);
        prbs(TM_SHORT_PRBS, PRBS_SHORT_RST_BIT, 12'hFF8);
        rst_n = 1'b0;
        repeat (12) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        reset_chk();
        finish_test();
    end

    // the full sequence needs under a third of this span
    initial
    begin
        #2000000;
        err_total++;
        finish_test();
    end
endmodule

bind acr_top acr_chk CHK (.clk_sys(clk_sys), .rst_n(rst_n), .spi_csb_n(spi_csb_n), .spi_sclk(spi_sclk),
    .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out), .spi_sdio_oe(spi_sdio_oe),
    .sample_strobe(sample_strobe), .sample_in(sample_in), .user_pattern(user_pattern),
    .data_out(data_out), .power_down(power_down), .standby(standby), .core_reset(core_reset),
    .dcs_enable(dcs_enable), .lvds_low_power(lvds_low_power));
